// file: hw/coproc_tlb_trap_decode.v
// coprocessor and translation trap decode with debug control registers
// What this block does
// RQ1: unusable coprocessor instruction raises unusable exception
// RQ2: software clears external coprocessor usability bits
// RQ3: coprocessor-0 moves execute, others are unsupported
// RQ4: four condition inputs tested by coprocessor branches
// RQ5: condition branch needs coprocessor usability bit set; the code lets coprocessor-0 branches run in kernel mode without it
// RQ6: translation maintenance instructions raise reserved exception
// RQ7: absent translation registers raise reserved exception
// RQ8: pc and data breakpoint registers, movable
// RQ9: debug and cache-invalidate control register held
// RQ10: invalidate enable with data cache invalidates line
// RQ11: invalidate enable without data cache suppresses store
// RQ12: instruction cache is four kilobytes
// RQ13: one-kilobyte data cache optional, controller disableable
// RQ14: on-chip memory gets a dedicated address range
// RQ15: integrator puts that range at a space end
// RQ16: any exception enters kernel until restore instruction
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/100ps
`include "coproc_defs.vh"
module coproc_tlb_trap_decode #(
	parameter HAS_DCACHE   = 1,
	parameter ICACHE_BYTES = 4096,
	parameter DCACHE_BYTES = 1024,
	parameter LINE_BYTES   = 16,
	parameter OCM_BASE     = 32'h0000_0000,
	parameter OCM_MASK     = 32'hffff_0000
) (
	input  wire        i_sys_clk,
	input  wire        i_arst_n,
	// instruction decode side
	input  wire        i_instr_valid,
	input  wire [31:0] i_instr,
	input  wire [31:0] i_pc,
	input  wire [31:0] i_rt_data,
	input  wire        i_ext_exc,
	input  wire [3:0]  i_cond,
	output reg         o_exc_valid,
	output reg  [4:0]  o_exc_code,
	output reg  [1:0]  o_exc_cp,
	output reg         o_br_valid,
	output reg         o_br_taken,
	output reg         o_mfc_valid,
	output reg  [31:0] o_mfc_data,
	output reg         o_user_mode,
	// store side
	input  wire        i_store_valid,
	input  wire [31:0] i_store_addr,
	output reg         o_mem_wr,
	output reg  [31:0] o_mem_wr_addr,
	output reg         o_ocm_sel,
	output reg         o_dinv,
	output reg  [5:0]  o_dinv_line,
	// fetch side
	input  wire [31:0] i_fetch_addr,
	output reg  [7:0]  o_ic_line,
	output reg  [19:0] o_ic_tag,
	// classic wishbone slave
	input  wire        i_wb_cyc,
	input  wire        i_wb_stb,
	input  wire        i_wb_we,
	input  wire [3:0]  i_wb_adr,
	input  wire [3:0]  i_wb_sel,
	input  wire [31:0] i_wb_dat,
	output reg  [31:0] o_wb_dat,
	output reg         o_wb_ack,
	output reg         o_irq
);
	// ==================================================
	// cache geometry
	localparam OFS_W = $clog2(LINE_BYTES);
	localparam IC_W  = $clog2(ICACHE_BYTES) - OFS_W; // [RQ12]
	localparam DC_W  = $clog2(DCACHE_BYTES) - OFS_W; // [RQ13]

	// ==================================================
	// state
	reg  [3:0]         usable_q;
	reg                user_q;
	reg                user_prev_q;
	reg  [31:0]        dbg_ctrl_q;
	reg  [`IRQ_W-1:0]  irq_stat_q;
	reg  [`IRQ_W-1:0]  irq_mask_q;
	reg                dc_dis_q;
	reg                s1_cpu;
	reg                s1_ri;
	reg  [1:0]         s1_cp;
	reg                s1_br;
	reg                s1_taken;
	reg                s1_mfc;
	reg                s1_rf;
	reg  [31:0]        s1_data;
	wire [3:0]         cond_s;
	wire [31:0]        rf_rdata;
	wire [63:0]        rf_all;

	// ==================================================
	// instruction fields
	wire [5:0] op    = i_instr[31:26];
	wire [1:0] cp    = op[1:0];
	wire [4:0] rs    = i_instr[25:21];
	wire [4:0] rd    = i_instr[15:11];
	wire [5:0] fn    = i_instr[5:0];
	wire       is_cop = (op[5:2] == `OP_COP_HI);
	wire       is_ldst = (op[5:2] == `OP_LWC_HI) || (op[5:2] == `OP_SWC_HI);
	wire       cp_ok = usable_q[cp] | (cp == 2'b00 & ~user_q);

	// ==================================================
	// decode
	reg        d_cpu;
	reg        d_ri;
	reg        d_br;
	reg        d_taken;
	reg        d_mfc;
	reg        d_mtc;
	reg        d_rfe;
	reg        d_rf;
	reg [31:0] d_data;
	always @* begin
		d_cpu   = 1'b0;
		d_ri    = 1'b0;
		d_br    = 1'b0;
		d_taken = 1'b0;
		d_mfc   = 1'b0;
		d_mtc   = 1'b0;
		d_rfe   = 1'b0;
		d_rf    = 1'b0;
		d_data  = 32'h0000_0000;
		if (i_instr_valid && (is_cop || is_ldst)) begin
			if (!cp_ok) begin
				d_cpu = 1'b1; // [RQ1]
			end else if (is_cop && rs == `RS_BC) begin
				d_br    = 1'b1; // [RQ4] [RQ5]
				d_taken = ~(cond_s[cp] ^ i_instr[16]);
			end else if (cp != 2'b00 || is_ldst) begin
				d_ri = 1'b1; // [RQ3]
			end else if (rs == `RS_MF || rs == `RS_MT) begin
				case (rd)
					`CP0_XLAT_INDEX, `CP0_XLAT_RANDOM, `CP0_XLAT_LOW,
					`CP0_XLAT_CTX, `CP0_XLAT_HIGH: begin
						d_ri = 1'b1; // [RQ7]
					end
					default: begin
						d_mfc = (rs == `RS_MF); // [RQ3]
						d_mtc = (rs == `RS_MT);
					end
				endcase
				d_rf = (rd == `CP0_BP_PC) || (rd == `CP0_BP_DATA);
				if (rd == `CP0_STATUS)
					d_data = {usable_q, 24'h00_0000, user_prev_q, 1'b0, user_q, 1'b0};
				else if (rd == `CP0_DBG_CTRL)
					d_data = dbg_ctrl_q;
			end else if (rs[4]) begin
				case (fn)
					`FN_XLAT_RD, `FN_XLAT_WI, `FN_XLAT_WR, `FN_XLAT_PROBE: begin
						d_ri = 1'b1; // [RQ6]
					end
					`FN_RFE: begin
						d_rfe = 1'b1;
					end
					default: begin
						d_ri = 1'b1;
					end
				endcase
			end else begin
				d_ri = 1'b1;
			end
		end
	end

	wire any_exc = d_cpu | d_ri | i_ext_exc;
	wire mtc_ok  = d_mtc & ~i_ext_exc;

	// ==================================================
	// condition inputs and breakpoint words
	cond_sync #(
		.N (4)
	) u_cond (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.i_async   (i_cond),
		.o_sync    (cond_s)
	);

	bp_regfile #(
		.WIDTH (32),
		.DEPTH (2),
		.AW    (1)
	) u_bp ( // [RQ8]
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.i_we      (mtc_ok & d_rf),
		.i_waddr   (rd[2]),
		.i_wdata   (i_rt_data),
		.i_raddr   (rd[2]),
		.o_rdata   (rf_rdata),
		.o_all     (rf_all)
	);

	wire pc_hit = i_instr_valid & dbg_ctrl_q[`DC_PC_BP_EN] & (i_pc == rf_all[31:0]);
	wire da_hit = i_store_valid & dbg_ctrl_q[`DC_DA_BP_EN] & (i_store_addr == rf_all[63:32]);

	// ==================================================
	// store handling
	wire dc_live  = (HAS_DCACHE != 0) & ~dc_dis_q; // [RQ13]
	wire dinv_on  = dbg_ctrl_q[`DC_DINV_EN];
	wire st_inv   = i_store_valid & dinv_on & dc_live; // [RQ10]
	wire st_supp  = i_store_valid & dinv_on & ~dc_live; // [RQ11]

	// ==================================================
	// mode and coprocessor 0 registers
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			usable_q    <= 4'h0;
			user_q      <= 1'b0;
			user_prev_q <= 1'b0;
			dbg_ctrl_q  <= `STATUS_RST;
		end else begin
			if (any_exc) begin
				user_q      <= 1'b0; // [RQ16]
				user_prev_q <= user_q;
			end else if (d_rfe) begin
				user_q <= user_prev_q; // [RQ16]
			end else if (mtc_ok && rd == `CP0_STATUS) begin
				usable_q    <= i_rt_data[`ST_CU_LO +: 4]; // [RQ2]
				user_q      <= i_rt_data[`ST_KU_CUR];
				user_prev_q <= i_rt_data[`ST_KU_PREV];
			end
			if (mtc_ok && rd == `CP0_DBG_CTRL)
				dbg_ctrl_q <= i_rt_data & `DBG_CTRL_MASK; // [RQ9]
			// hit flags: set wins over a clearing write
			if (pc_hit)
				dbg_ctrl_q[`DC_PC_HIT] <= 1'b1;
			if (da_hit)
				dbg_ctrl_q[`DC_DA_HIT] <= 1'b1;
		end
	end

	// ==================================================
	// two-stage result pipe, read data from the word store arrives late
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s1_cpu      <= 1'b0;
			s1_ri       <= 1'b0;
			s1_cp       <= 2'b00;
			s1_br       <= 1'b0;
			s1_taken    <= 1'b0;
			s1_mfc      <= 1'b0;
			s1_rf       <= 1'b0;
			s1_data     <= 32'h0000_0000;
			o_exc_valid <= 1'b0;
			o_exc_code  <= 5'h00;
			o_exc_cp    <= 2'b00;
			o_br_valid  <= 1'b0;
			o_br_taken  <= 1'b0;
			o_mfc_valid <= 1'b0;
			o_mfc_data  <= 32'h0000_0000;
			o_user_mode <= 1'b0;
		end else begin
			s1_cpu      <= d_cpu;
			s1_ri       <= d_ri;
			s1_cp       <= cp;
			s1_br       <= d_br;
			s1_taken    <= d_taken;
			s1_mfc      <= d_mfc;
			s1_rf       <= d_rf;
			s1_data     <= d_data;
			o_exc_valid <= s1_cpu | s1_ri;
			o_exc_code  <= s1_cpu ? `EXC_CPU : (s1_ri ? `EXC_RI : 5'h00);
			o_exc_cp    <= s1_cp;
			o_br_valid  <= s1_br;
			o_br_taken  <= s1_br & s1_taken;
			o_mfc_valid <= s1_mfc;
			o_mfc_data  <= s1_rf ? rf_rdata : s1_data;
			o_user_mode <= user_q;
		end
	end

	// ==================================================
	// store, on-chip memory and fetch outputs
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mem_wr      <= 1'b0;
			o_mem_wr_addr <= 32'h0000_0000;
			o_ocm_sel     <= 1'b0;
			o_dinv        <= 1'b0;
			o_dinv_line   <= 6'h00;
			o_ic_line     <= 8'h00;
			o_ic_tag      <= 20'h0_0000;
		end else begin
			o_mem_wr      <= i_store_valid & ~st_supp; // [RQ11]
			o_mem_wr_addr <= i_store_addr;
			// fixed window keeps the rest of the space contiguous
			o_ocm_sel     <= i_store_valid & ~st_supp &
				((i_store_addr & OCM_MASK) == OCM_BASE); // [RQ14]
			o_dinv        <= st_inv; // [RQ10]
			o_dinv_line   <= i_store_addr[OFS_W +: DC_W];
			o_ic_line     <= i_fetch_addr[OFS_W +: IC_W]; // [RQ12]
			o_ic_tag      <= i_fetch_addr[31 -: 20];
		end
	end

	// ==================================================
	// wishbone slave and interrupt
	wire        wb_req  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	wire        wb_wr   = wb_req & i_wb_we;
	wire [31:0] bmask   = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
		{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
	wire [31:0] wdat    = i_wb_dat & bmask;
	wire [`IRQ_W-1:0] ev = {st_supp, da_hit, pc_hit, d_ri, d_cpu};
	reg  [31:0] rdat;
	always @* begin
		case (i_wb_adr)
			`WB_IRQ_STAT: rdat = {27'h000_0000, irq_stat_q};
			`WB_IRQ_MASK: rdat = {27'h000_0000, irq_mask_q};
			`WB_CTRL:     rdat = {31'h0000_0000, dc_dis_q};
			`WB_STATE:    rdat = {20'h0_0000, cond_s, usable_q, 3'b000, ~user_q};
			default:      rdat = 32'h0000_0000;
		endcase
	end

	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_stat_q <= 5'h00;
			irq_mask_q <= `IRQ_MASK_RST;
			dc_dis_q   <= 1'b0;
			o_wb_ack   <= 1'b0;
			o_wb_dat   <= 32'h0000_0000;
			o_irq      <= 1'b0;
		end else begin
			o_wb_ack <= wb_req;
			o_wb_dat <= wb_req ? rdat : 32'h0000_0000;
			// new events win over the one-to-clear write
			irq_stat_q <= (irq_stat_q &
				~((wb_wr && i_wb_adr == `WB_IRQ_STAT) ? wdat[`IRQ_W-1:0] : 5'h00)) | ev;
			if (wb_wr && i_wb_adr == `WB_IRQ_MASK)
				irq_mask_q <= (irq_mask_q & ~bmask[`IRQ_W-1:0]) | wdat[`IRQ_W-1:0];
			if (wb_wr && i_wb_adr == `WB_CTRL && i_wb_sel[0])
				dc_dis_q <= i_wb_dat[`CTRL_DC_DIS];
			o_irq <= |(irq_stat_q & irq_mask_q);
		end
	end
endmodule

// file: hw/coproc_defs.vh
// constants for the coprocessor trap decode block
`ifndef COPROC_DEFS_VH
`define COPROC_DEFS_VH

// ==================================================
// instruction fields
`define OP_COP_HI       4'h4
`define OP_LWC_HI       4'hc
`define OP_SWC_HI       4'he
`define RS_MF           5'h00
`define RS_CF           5'h02
`define RS_MT           5'h04
`define RS_CT           5'h06
`define RS_BC           5'h08
`define FN_XLAT_RD      6'h01
`define FN_XLAT_WI      6'h02
`define FN_XLAT_WR      6'h06
`define FN_XLAT_PROBE   6'h08
`define FN_RFE          6'h10

// ==================================================
// system control coprocessor register numbers
`define CP0_XLAT_INDEX  5'h00
`define CP0_XLAT_RANDOM 5'h01
`define CP0_XLAT_LOW    5'h02
`define CP0_BP_PC       5'h03
`define CP0_XLAT_CTX    5'h04
`define CP0_BP_DATA     5'h05
`define CP0_DBG_CTRL    5'h07
`define CP0_XLAT_HIGH   5'h0a
`define CP0_STATUS      5'h0c

// ==================================================
// field positions
`define ST_KU_CUR       1
`define ST_KU_PREV      3
`define ST_CU_LO        28
`define DC_PC_HIT       0
`define DC_DA_HIT       1
`define DC_DINV_EN      13
`define DC_PC_BP_EN     24
`define DC_DA_BP_EN     25
`define DBG_CTRL_MASK   32'h0300_2003

// ==================================================
// exception codes
`define EXC_RI          5'h0a
`define EXC_CPU         5'h0b

// ==================================================
// bus register map and reset values
`define WB_IRQ_STAT     4'h0
`define WB_IRQ_MASK     4'h4
`define WB_CTRL         4'h8
`define WB_STATE        4'hc
`define IRQ_CPU         0
`define IRQ_RI          1
`define IRQ_PC_BP       2
`define IRQ_DA_BP       3
`define IRQ_ST_SUPP     4
`define IRQ_W           5
`define IRQ_MASK_RST    5'h00
`define CTRL_DC_DIS     0
`define STATUS_RST      32'h0000_0000

`endif

// file: hw/cond_sync.v
// two-stage synchroniser for the external condition inputs
`timescale 1ns/100ps
module cond_sync #(
	parameter N = 4
) (
	input  wire         i_sys_clk,
	input  wire         i_arst_n,
	input  wire [N-1:0] i_async,
	output wire [N-1:0] o_sync
);
	// ==================================================
	// one pair of flops per bit
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_bit
			reg meta_q;
			reg sync_q;
			always @(posedge i_sys_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end else begin
					meta_q <= i_async[g];
					sync_q <= meta_q;
				end
			end
			assign o_sync[g] = sync_q;
		end
	endgenerate
endmodule

// file: hw/bp_regfile.v
// small word store for the breakpoint address registers
`timescale 1ns/100ps
module bp_regfile #(
	parameter WIDTH = 32,
	parameter DEPTH = 2,
	parameter AW    = 1
) (
	input  wire                   i_sys_clk,
	input  wire                   i_arst_n,
	input  wire                   i_we,
	input  wire [AW-1:0]          i_waddr,
	input  wire [WIDTH-1:0]       i_wdata,
	input  wire [AW-1:0]          i_raddr,
	output reg  [WIDTH-1:0]       o_rdata,
	output wire [DEPTH*WIDTH-1:0] o_all
);
	// ==================================================
	// storage, read data registered
	genvar g;
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : g_word
			reg [WIDTH-1:0] word_q;
			always @(posedge i_sys_clk or negedge i_arst_n) begin
				if (!i_arst_n)
					word_q <= {WIDTH{1'b0}};
				else if (i_we && i_waddr == g)
					word_q <= i_wdata;
			end
			assign o_all[g*WIDTH +: WIDTH] = word_q;
		end
	endgenerate

	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			o_rdata <= {WIDTH{1'b0}};
		else
			o_rdata <= o_all[i_raddr*WIDTH +: WIDTH];
	end
endmodule

// file: verification/coproc_trap_props.sv
// assertion checker for the coprocessor trap decode block
`timescale 1ns/100ps
`include "coproc_defs.vh"
module coproc_trap_props (
	input wire        i_sys_clk,
	input wire        i_arst_n,
	input wire        i_instr_valid,
	input wire [31:0] i_instr,
	input wire        i_store_valid,
	input wire [31:0] i_store_addr,
	input wire [31:0] i_fetch_addr,
	input wire        o_exc_valid,
	input wire [4:0]  o_exc_code,
	input wire [1:0]  o_exc_cp,
	input wire        o_br_valid,
	input wire        o_mfc_valid,
	input wire        o_user_mode,
	input wire        o_mem_wr,
	input wire [31:0] o_mem_wr_addr,
	input wire        o_dinv,
	input wire [5:0]  o_dinv_line,
	input wire [7:0]  o_ic_line,
	input wire [19:0] o_ic_tag
);
	// ==========================================
	// sequences
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	wire [4:0] rd = i_instr[15:11];
	sequence s_xlat_op;
		i_instr_valid && i_instr[31:25] == 7'h21 && (i_instr[5:0] == `FN_XLAT_RD
		|| i_instr[5:0] == `FN_XLAT_WI || i_instr[5:0] == `FN_XLAT_WR
		|| i_instr[5:0] == `FN_XLAT_PROBE);
	endsequence
	sequence s_absent_reg;
		i_instr_valid && i_instr[31:26] == 6'h10 && (i_instr[25:21] == `RS_MF
		|| i_instr[25:21] == `RS_MT) && (rd == 5'h00 || rd == 5'h01 || rd == 5'h02
		|| rd == 5'h04 || rd == 5'h0a);
	endsequence
	sequence s_trap2;
		##2 o_exc_valid;
	endsequence
	// ==========================================
	// properties
	xlat_trap_a: assert property (s_xlat_op |-> s_trap2)
		else $error("translation op not trapped");
	absent_reg_a: assert property (s_absent_reg |-> s_trap2)
		else $error("absent register access not trapped");
	cop_ldst_a: assert property (i_instr_valid && i_instr[27:26] != 2'h0 &&
		(i_instr[31:28] == `OP_LWC_HI || i_instr[31:28] == `OP_SWC_HI) |-> s_trap2)
		else $error("coprocessor load or store not trapped");
	exc_cp_a: assert property (i_instr_valid && i_instr[31:28] == `OP_COP_HI
		|-> ##2 (!o_exc_valid || o_exc_cp == $past(i_instr[27:26], 2)))
		else $error("wrong coprocessor number");
	exc_code_a: assert property (o_exc_valid |->
		(o_exc_code == `EXC_RI || o_exc_code == `EXC_CPU))
		else $error("bad exception code");
	quiet_decode_a: assert property (!i_instr_valid |->
		##2 !(o_exc_valid || o_br_valid || o_mfc_valid))
		else $error("decode output without instruction");
	exc_kernel_a: assert property (o_exc_valid |-> ##[0:3] !o_user_mode)
		else $error("exception left user mode on");
	dinv_line_a: assert property (o_dinv |-> o_mem_wr &&
		o_dinv_line == o_mem_wr_addr[9:4])
		else $error("invalidate line mismatch");
	store_addr_a: assert property (i_store_valid |=>
		!o_mem_wr || o_mem_wr_addr == $past(i_store_addr))
		else $error("store address mismatch");
	no_store_a: assert property (!i_store_valid |=> !o_mem_wr && !o_dinv)
		else $error("write without store");
	ic_split_a: assert property ($past(i_arst_n) |->
		o_ic_line == $past(i_fetch_addr[11:4]) && o_ic_tag == $past(i_fetch_addr[31:12]))
		else $error("icache index split wrong");
endmodule

bind coproc_tlb_trap_decode coproc_trap_props u_props (
	.i_sys_clk, .i_arst_n, .i_instr_valid, .i_instr, .i_store_valid, .i_store_addr,
	.i_fetch_addr, .o_exc_valid, .o_exc_code, .o_exc_cp, .o_br_valid, .o_mfc_valid,
	.o_user_mode, .o_mem_wr, .o_mem_wr_addr, .o_dinv, .o_dinv_line, .o_ic_line, .o_ic_tag
);

// file: verification/cond_hw.sv
// condition-signal hardware model driving the four external inputs
`timescale 1ns/100ps
module cond_hw (
	input  wire       i_sys_clk,
	input  wire [3:0] i_level,
	output reg  [3:0] o_cond
);
	// unrelated hardware: changes away from the core edge
	initial o_cond = 4'h0;
	always @(negedge i_sys_clk) begin
		o_cond <= i_level;
	end
endmodule

// file: verification/tb_top.sv
// self-checking bench for the coprocessor trap decode block
`timescale 1ns/100ps
`include "coproc_defs.vh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
	$display("Error %s exp %h got %h", nm, ex, got); end end
module tb_top;
	localparam [31:0] OCM_B = 32'h0000_0000; // window at the bottom of the space
	localparam [31:0] OCM_M = 32'hffff_0000;
	localparam [31:0] MF0 = 32'h4001_0000;
	localparam [31:0] MT0 = 32'h4080_0000;
	localparam [31:0] CO0 = 32'h4200_0000;
	reg         i_sys_clk = 1'b0, i_arst_n = 1'b0;
	reg         i_instr_valid = 1'b0, i_store_valid = 1'b0;
	reg  [31:0] i_instr = 32'h0000_0000, i_rt_data = 32'h0000_0000;
	reg  [31:0] i_store_addr = 32'h0000_0000, i_fetch_addr = 32'h0000_0000;
	reg  [3:0]  cond_level = 4'h0, i_wb_adr = 4'h0;
	reg         i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
	reg  [31:0] i_wb_dat = 32'h0000_0000, rd_q;
	wire [3:0]  i_cond;
	wire        o_exc_valid, o_br_valid, o_br_taken, o_mfc_valid, o_user_mode;
	wire        o_mem_wr, o_ocm_sel, o_dinv, o_wb_ack, o_irq;
	wire [4:0]  o_exc_code;
	wire [1:0]  o_exc_cp;
	wire [5:0]  o_dinv_line;
	wire [7:0]  o_ic_line;
	wire [19:0] o_ic_tag;
	wire [31:0] o_mfc_data, o_mem_wr_addr, o_wb_dat;
	integer     error_cnt = 0, n_tests = 0, i, z;
	reg  [4:0]  absent [5] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h0a};
	reg  [5:0]  xfn [4] = '{6'h01, 6'h02, 6'h06, 6'h08};

	// ==========================================
	// design and partner
	coproc_tlb_trap_decode #(.OCM_BASE(OCM_B), .OCM_MASK(OCM_M)) u_dut (
		.i_sys_clk, .i_arst_n, .i_instr_valid, .i_instr, .i_pc(32'h0000_0000), .i_rt_data,
		.i_ext_exc(1'b0), .i_cond, .o_exc_valid, .o_exc_code, .o_exc_cp, .o_br_valid,
		.o_br_taken, .o_mfc_valid, .o_mfc_data, .o_user_mode, .i_store_valid,
		.i_store_addr, .o_mem_wr, .o_mem_wr_addr, .o_ocm_sel, .o_dinv, .o_dinv_line,
		.i_fetch_addr, .o_ic_line, .o_ic_tag, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
		.i_wb_sel(4'hf), .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_irq);
	cond_hw u_cond (.i_sys_clk(i_sys_clk), .i_level(cond_level), .o_cond(i_cond));

	always #5 i_sys_clk = ~i_sys_clk;
	// moving fetch address keeps the index split busy all run
	always @(posedge i_sys_clk) i_fetch_addr <= i_fetch_addr + 32'h0000_1010;

	// ==========================================
	// tasks
	task automatic settle(input integer n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic wb(input bit we, input [3:0] adr, input [31:0] dat);
		integer t;
		@(posedge i_sys_clk);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_adr <= adr;
		i_wb_dat <= dat;
		t = 0;
		do begin
			@(posedge i_sys_clk);
			t++;
		end while (o_wb_ack !== 1'b1 && t < 20);
		rd_q = o_wb_dat;
		`CHK("wb_ack", 1'b1, o_wb_ack)
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
	endtask
	task automatic dec(input [31:0] ins, input [31:0] rt);
		@(posedge i_sys_clk);
		i_instr_valid <= 1'b1;
		i_instr <= ins;
		i_rt_data <= rt;
		@(posedge i_sys_clk);
		i_instr_valid <= 1'b0;
		settle(1);
	endtask
	task automatic trap(input [31:0] ins, input [4:0] code, input [1:0] cp);
		dec(ins, 32'h0000_0000);
		`CHK("exc_valid", 1'b1, o_exc_valid)
		`CHK("exc_code", code, o_exc_code)
		`CHK("exc_cp", cp, o_exc_cp)
		`CHK("br_valid", 1'b0, o_br_valid)
	endtask
	task automatic st(input [31:0] a, input bit wr, input bit inv);
		@(posedge i_sys_clk);
		i_store_valid <= 1'b1;
		i_store_addr <= a;
		@(posedge i_sys_clk);
		i_store_valid <= 1'b0;
		#1;
		`CHK("mem_wr", wr, o_mem_wr)
		`CHK("dinv", inv, o_dinv)
		if (inv) `CHK("dinv_line", a[9:4], o_dinv_line)
		if (wr) `CHK("ocm_sel", (a & OCM_M) == OCM_B, o_ocm_sel)
	endtask
	task automatic conclude;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================
	// tests
	initial begin
		#100000;
		error_cnt++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge i_sys_clk);
		i_arst_n <= 1'b1;
		wb(1'b0, `WB_STATE, 32'h0000_0000);
		`CHK("state_rst", 32'h0000_0001, rd_q)
		wb(1'b0, 4'h2, 32'h0000_0000);
		`CHK("unmapped", 32'h0000_0000, rd_q)
		dec(MT0 | 32'h0000_6000, 32'h0000_0000);
		for (i = 0; i < 2; i++) begin
			dec(MT0 | {16'h0000, i ? `CP0_BP_DATA : `CP0_BP_PC, 11'h000}, 32'ha5c3_0f10 + i);
			`CHK("mtc_exc", 1'b0, o_exc_valid)
			dec(MF0 | {16'h0000, i ? `CP0_BP_DATA : `CP0_BP_PC, 11'h000}, 32'h0000_0000);
			`CHK("mfc_valid", 1'b1, o_mfc_valid)
			`CHK("mfc_data", 32'ha5c3_0f10 + i, o_mfc_data)
		end
		for (i = 0; i < 10; i++)
			trap((i < 5 ? MF0 : MT0) | {16'h0000, absent[i % 5], 11'h000}, `EXC_RI, 2'h0);
		for (i = 0; i < 4; i++)
			trap(CO0 | xfn[i], `EXC_RI, 2'h0);
		for (z = 1; z < 4; z++) begin
			trap(MT0 | (z << 26), `EXC_CPU, z);
			trap(32'hc000_0000 | (z << 26), `EXC_CPU, z);
			trap(32'h4100_0000 | (z << 26), `EXC_CPU, z);
		end
		cond_level <= 4'h6;
		dec(MT0 | 32'h0000_6000, 32'hf000_0000);
		dec(MF0 | 32'h0000_6000, 32'h0000_0000);
		`CHK("status", 32'hf000_0000, o_mfc_data)
		wb(1'b0, `WB_STATE, 32'h0000_0000);
		`CHK("state_cond", 32'h0000_06f1, rd_q)
		for (i = 0; i < 8; i++) begin
			dec(32'h4100_0000 | ((i >> 1) << 26) | ((i & 1) << 16), 32'h0000_0000);
			`CHK("br_valid", 1'b1, o_br_valid)
			`CHK("br_taken", cond_level[i >> 1] == i[0], o_br_taken)
		end
		trap(MT0 | (1 << 26), `EXC_RI, 2'h1);
		wb(1'b1, `WB_IRQ_STAT, 32'h0000_001f);
		st(32'h0000_0120, 1'b1, 1'b0);
		dec(MT0 | 32'h0000_3800, 32'h0000_2000);
		dec(MF0 | 32'h0000_3800, 32'h0000_0000);
		`CHK("dbg_ctrl", 32'h0000_2000, o_mfc_data)
		st(32'h8000_03f4, 1'b1, 1'b1);
		st(32'h0000_0a50, 1'b1, 1'b1);
		dec(MT0 | 32'h0000_3800, 32'h0200_0000);
		st(32'ha5c3_0f11, 1'b1, 1'b0);
		dec(MF0 | 32'h0000_3800, 32'h0000_0000);
		`CHK("da_hit", 32'h0200_0002, o_mfc_data)
		dec(MT0 | 32'h0000_3800, 32'h0000_2000);
		wb(1'b1, `WB_CTRL, 32'h0000_0001);
		st(32'h0000_0040, 1'b0, 1'b0);
		wb(1'b0, `WB_IRQ_STAT, 32'h0000_0000);
		`CHK("irq_stat", 32'h0000_0018, rd_q)
		`CHK("irq_masked", 1'b0, o_irq)
		wb(1'b1, `WB_IRQ_MASK, 32'h0000_0010);
		settle(2);
		`CHK("irq_on", 1'b1, o_irq)
		wb(1'b1, `WB_IRQ_STAT, 32'h0000_0010);
		settle(2);
		`CHK("irq_off", 1'b0, o_irq)
		wb(1'b1, `WB_CTRL, 32'h0000_0000);
		dec(MT0 | 32'h0000_6000, 32'h0000_0002);
		settle(1);
		`CHK("user", 1'b1, o_user_mode)
		trap(MF0 | 32'h0000_6000, `EXC_CPU, 2'h0);
		settle(2);
		`CHK("kernel", 1'b0, o_user_mode)
		dec(CO0 | `FN_RFE, 32'h0000_0000);
		settle(1);
		`CHK("restore", 1'b1, o_user_mode)
		conclude();
	end
endmodule
